// ===== rtl/ddrb_pkg.sv
// Shared constants, state codes and mode-word decoders for the burst device.
// Assumes nothing beyond a SystemVerilog compiler; included by every design file.
package ddrb_pkg;

  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;

  // Command codes on {row_strobe_n, col_strobe_n, write_en_n} with cmd_sel_n low
  localparam logic [2:0] CMD_ACTIVE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_MODE_SET = 3'h0;
  localparam logic [1:0] MODE_BANK_SEL = 2'h0;

  // Mode word layout
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_ORDER_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_OP_LSB = 7;
  localparam int DLL_RESET_BIT = 8;
  localparam int AUTO_PRE_BIT = 10;
  localparam int ALL_BANKS_BIT = 10;
  localparam logic [12:0] MODE_RESET = 13'h0000;

  localparam logic [2:0] BL2_CODE = 3'h1;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] CL2_CODE = 3'h2;
  localparam logic [2:0] CL25_CODE = 3'h6;
  localparam logic [2:0] CL3_CODE = 3'h3;
  localparam logic [5:0] OP_NORMAL = 6'h00;
  localparam logic [5:0] OP_DLL_RESET = 6'h02;

  // System-clock cycles without link activity before the clock pair is reported lost
  localparam logic [4:0] ALIVE_TIMEOUT = 5'h10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_XFER = 3'b100
  } ddrb_burst_state_t;

  // Reserved length codes fall back to the shortest burst
  function automatic logic [1:0] ddrb_bl_log(input logic [2:0] code);
    case (code)
      BL4_CODE: ddrb_bl_log = 2'd2;
      BL8_CODE: ddrb_bl_log = 2'd3;
      default: ddrb_bl_log = 2'd1;
    endcase
  endfunction

  function automatic logic [2:0] ddrb_blk_mask(input logic [1:0] bl_log);
    case (bl_log)
      2'd1: ddrb_blk_mask = 3'h1;
      2'd2: ddrb_blk_mask = 3'h3;
      default: ddrb_blk_mask = 3'h7;
    endcase
  endfunction

  // Extra wait cycles beyond the shortest latency; reserved codes act as latency 2
  function automatic logic [1:0] ddrb_cl_wait(input logic [2:0] code);
    case (code)
      CL3_CODE: ddrb_cl_wait = 2'd1;
      default: ddrb_cl_wait = 2'd0;
    endcase
  endfunction

endpackage : ddrb_pkg

// ===== rtl/ddrb_burst_col.sv
// Column generator for one beat of a burst: wraps inside the aligned block.
// Assumes COL_W of at least 3 so a full eight-location block fits.
module ddrb_burst_col
  import ddrb_pkg::*;
#(
  parameter int COL_W = 4
) (
  input wire logic [COL_W-1:0] start_col,
  input wire logic [2:0] beat,
  input wire logic [1:0] bl_log,
  input wire logic interleave,
  output logic [COL_W-1:0] col
);

  logic [2:0] mask;
  logic [2:0] low;

  always_comb begin
    mask = ddrb_blk_mask(bl_log);
    if (interleave) begin
      low = start_col[2:0] ^ beat;
    end else begin
      low = start_col[2:0] + beat;
    end
    col = start_col;
    col[2:0] = (start_col[2:0] & ~mask) | (low & mask);
  end

endmodule // ddrb_burst_col

// ===== rtl/ddrb_device.sv
// Device end of a double-data-rate DRAM link: commands, banks, bursts, mode word.
// Assumes a pad layer splitting each DQ/DQS pin into rise and fall half-cycle lanes
// and resolving the shared wires from the output enables; the link clock runs free.

module ddrb_device
  import ddrb_pkg::*;
#(
  parameter int DQ_W = 8,
  parameter int ROW_W = 2,
  parameter int COL_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic true_clock,
  input wire logic complement_clock,
  input wire logic cmd_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_en_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_in_rise,
  input wire logic [DQ_W-1:0] dq_in_fall,
  input wire logic dqs_in_rise,
  input wire logic dqs_in_fall,
  output logic [DQ_W-1:0] dq_out_rise,
  output logic [DQ_W-1:0] dq_out_fall,
  output logic dq_oe,
  output logic dqs_out_rise,
  output logic dqs_out_fall,
  output logic dqs_oe,
  output logic [ADDR_W-1:0] cfg_word_view,
  output logic [NUM_BANKS-1:0] bank_open_view,
  output logic dll_reset_pulse,
  output logic clock_pair_ok
);

  localparam int IDX_W = BANK_W + ROW_W + COL_W;
  localparam int DEPTH = 1 << IDX_W;

  // ----------------------------------------------------------------------
  // Link-domain reset and enable
  // ----------------------------------------------------------------------
  logic [1:0] lrst_reg;
  logic link_rst_n;
  logic en_s1_reg;
  logic en_s2_reg;
  logic link_en;

  always_ff @(posedge true_clock or negedge rst_n) begin
    if (!rst_n) begin
      lrst_reg <= 2'b00;
    end else begin
      lrst_reg <= {lrst_reg[0], 1'b1};
    end
  end
  assign link_rst_n = lrst_reg[1];

  always_ff @(posedge true_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
    end else begin
      en_s1_reg <= clk_en;
      en_s2_reg <= en_s1_reg;
    end
  end
  assign link_en = en_s2_reg;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic [2:0] cmd;
  logic [BANK_W-1:0] bank_in;
  logic is_act, is_rd, is_wr, is_pre, is_mset;

  assign cmd = {row_strobe_n, col_strobe_n, write_en_n};
  assign bank_in = {bank_select_high, bank_select_low};
  assign is_act = link_en && !cmd_sel_n && cmd == CMD_ACTIVE;
  assign is_rd = link_en && !cmd_sel_n && cmd == CMD_READ;
  assign is_wr = link_en && !cmd_sel_n && cmd == CMD_WRITE;
  assign is_pre = link_en && !cmd_sel_n && cmd == CMD_PRECHARGE;
  assign is_mset = link_en && !cmd_sel_n && cmd == CMD_MODE_SET && bank_in == MODE_BANK_SEL;

  // ----------------------------------------------------------------------
  // Mode word
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0] mode_reg;
  logic [1:0] cur_bl_log;
  logic [2:0] cur_cl;

  // The word is held until rewritten; only the DLL bit drops on its own
  always_ff @(posedge true_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      mode_reg <= MODE_RESET;
    end else if (link_en) begin
      if (is_mset) begin
        mode_reg <= addr;
      end else begin
        mode_reg[DLL_RESET_BIT] <= 1'b0;
      end
    end
  end
  assign cur_bl_log = ddrb_bl_log(mode_reg[MODE_BL_LSB +: 3]);
  assign cur_cl = mode_reg[MODE_CL_LSB +: 3];

  // ----------------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------------
  logic [NUM_BANKS-1:0] bank_open_reg;
  logic [ROW_W-1:0] row_reg [NUM_BANKS];
  ddrb_burst_state_t st_reg;
  logic b_wr_reg, b_ap_reg, b_half_reg, b_inter_reg;
  logic [BANK_W-1:0] b_bank_reg;
  logic [COL_W-1:0] b_col_reg;
  logic [1:0] b_bl_log_reg;
  logic [1:0] wait_reg;
  logic [2:0] word_reg;
  logic [2:0] last_word;
  logic at_last;

  assign last_word = 3'(3'h1 << (b_bl_log_reg - 2'd1)) - 3'h1 + {2'b00, b_half_reg};
  assign at_last = st_reg == ST_XFER && word_reg == last_word;

  always_ff @(posedge true_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bank_open_reg <= '0;
      for (int b = 0; b < NUM_BANKS; b++) begin
        row_reg[b] <= '0;
      end
    end else if (link_en) begin
      if (at_last && b_ap_reg) begin
        bank_open_reg[b_bank_reg] <= 1'b0;
      end
      if (is_act) begin
        bank_open_reg[bank_in] <= 1'b1;
        row_reg[bank_in] <= addr[ROW_W-1:0];
      end else if (is_pre) begin
        if (addr[ALL_BANKS_BIT]) begin
          bank_open_reg <= '0;
        end else begin
          bank_open_reg[bank_in] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Burst engine
  // ----------------------------------------------------------------------
  // A new read or write cuts short any burst still running
  always_ff @(posedge true_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_reg <= ST_IDLE;
      b_wr_reg <= 1'b0;
      b_ap_reg <= 1'b0;
      b_half_reg <= 1'b0;
      b_inter_reg <= 1'b0;
      b_bank_reg <= '0;
      b_col_reg <= '0;
      b_bl_log_reg <= 2'd1;
      wait_reg <= 2'd0;
      word_reg <= 3'd0;
    end else if (link_en) begin
      if (is_rd || is_wr) begin
        st_reg <= is_rd ? ST_WAIT : ST_XFER;
        wait_reg <= ddrb_cl_wait(cur_cl);
        b_wr_reg <= is_wr;
        b_bank_reg <= bank_in;
        b_col_reg <= addr[COL_W-1:0];
        b_ap_reg <= addr[AUTO_PRE_BIT];
        b_bl_log_reg <= cur_bl_log;
        b_inter_reg <= mode_reg[MODE_ORDER_BIT];
        b_half_reg <= is_rd && cur_cl == CL25_CODE;
        word_reg <= 3'd0;
      end else begin
        case (st_reg)
          ST_IDLE: begin
            word_reg <= 3'd0;
          end
          ST_WAIT: begin
            if (wait_reg == 2'd0) begin
              st_reg <= ST_XFER;
            end else begin
              wait_reg <= wait_reg - 2'd1;
            end
          end
          ST_XFER: begin
            word_reg <= word_reg + 3'd1;
            if (at_last) begin
              st_reg <= ST_IDLE;
            end
          end
          default: begin
            st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Lanes and storage
  // ----------------------------------------------------------------------
  logic [COL_W-1:0] lane_col [2];
  logic [IDX_W-1:0] lane_idx [2];
  logic [DQ_W-1:0] mem [DEPTH];
  logic [DQ_W-1:0] carry_reg;
  logic wr_take;

  // Each core cycle serves two consecutive beats of the burst, the even beat on lane 0 and the odd beat on lane 1
  for (genvar l = 0; l < 2; l++) begin : g_lane
    ddrb_burst_col #(.COL_W(COL_W)) u_col (
      .start_col(b_col_reg),
      .beat({word_reg[1:0], 1'(l)}),
      .bl_log(b_bl_log_reg),
      .interleave(b_inter_reg),
      .col(lane_col[l])
    );
    assign lane_idx[l] = {b_bank_reg, row_reg[b_bank_reg], lane_col[l]};
  end

  // A full strobe pulse in the cycle marks both halves as valid
  assign wr_take = link_en && st_reg == ST_XFER && b_wr_reg && dqs_in_rise && !dqs_in_fall;

  // Only bursts write the array, so a mode set leaves it intact
  always_ff @(posedge true_clock) begin
    if (wr_take) begin
      mem[lane_idx[0]] <= dq_in_rise;
      mem[lane_idx[1]] <= dq_in_fall;
    end
  end

  // ----------------------------------------------------------------------
  // Read launch
  // ----------------------------------------------------------------------
  // Latency 2.5 shifts the stream by one half: the odd beat is carried over
  always_ff @(posedge true_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dq_out_rise <= '0;
      dq_out_fall <= '0;
      carry_reg <= '0;
      dq_oe <= 1'b0;
      dqs_out_rise <= 1'b0;
      dqs_out_fall <= 1'b0;
      dqs_oe <= 1'b0;
    end else if (link_en) begin
      if (st_reg == ST_XFER && !b_wr_reg) begin
        dq_oe <= 1'b1;
        dqs_oe <= 1'b1;
        if (b_half_reg) begin
          dq_out_rise <= carry_reg;
          dq_out_fall <= mem[lane_idx[0]];
          carry_reg <= mem[lane_idx[1]];
          dqs_out_rise <= 1'b0;
          dqs_out_fall <= !at_last;
        end else begin
          dq_out_rise <= mem[lane_idx[0]];
          dq_out_fall <= mem[lane_idx[1]];
          dqs_out_rise <= 1'b1;
          dqs_out_fall <= 1'b0;
        end
      end else begin
        dq_oe <= 1'b0;
        dqs_oe <= 1'b0;
        dqs_out_rise <= 1'b0;
        dqs_out_fall <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crossings to the system clock
  // ----------------------------------------------------------------------
  logic mode_req_reg, mode_pend_reg, ack_s1_reg, ack_s2_reg, mode_ack_reg;
  logic [ADDR_W-1:0] mode_hold_reg;
  logic dll_tgl_reg, hb_reg;

  // The held word stays put until the other side has acknowledged it
  always_ff @(posedge true_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      mode_req_reg <= 1'b0;
      mode_pend_reg <= 1'b0;
      mode_hold_reg <= MODE_RESET;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      dll_tgl_reg <= 1'b0;
      hb_reg <= 1'b0;
    end else begin
      ack_s1_reg <= mode_ack_reg;
      ack_s2_reg <= ack_s1_reg;
      hb_reg <= !hb_reg;
      if (link_en) begin
        if (is_mset && addr[MODE_OP_LSB +: 6] == OP_DLL_RESET) begin
          dll_tgl_reg <= !dll_tgl_reg;
        end
        if (mode_pend_reg && ack_s2_reg == mode_req_reg) begin
          mode_hold_reg <= mode_reg & ~(13'h0001 << DLL_RESET_BIT);
          mode_req_reg <= !mode_req_reg;
          mode_pend_reg <= is_mset;
        end else if (is_mset) begin
          mode_pend_reg <= 1'b1;
        end
      end
    end
  end

  logic req_s1_reg, req_s2_reg;
  logic dll_s1_reg, dll_s2_reg, dll_s3_reg;
  logic hb_s1_reg, hb_s2_reg, hb_s3_reg;
  logic cc_s1_reg, cc_s2_reg, cc_s3_reg;
  logic [NUM_BANKS-1:0] bo_s1_reg;
  logic [4:0] hb_age_reg, cc_age_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {req_s1_reg, req_s2_reg, mode_ack_reg} <= 3'h0;
      {dll_s1_reg, dll_s2_reg, dll_s3_reg} <= 3'h0;
      {hb_s1_reg, hb_s2_reg, hb_s3_reg} <= 3'h0;
      {cc_s1_reg, cc_s2_reg, cc_s3_reg} <= 3'h0;
      bo_s1_reg <= '0;
      bank_open_view <= '0;
      cfg_word_view <= MODE_RESET;
      dll_reset_pulse <= 1'b0;
    end else if (clk_en) begin
      {req_s2_reg, req_s1_reg} <= {req_s1_reg, mode_req_reg};
      {dll_s3_reg, dll_s2_reg, dll_s1_reg} <= {dll_s2_reg, dll_s1_reg, dll_tgl_reg};
      {hb_s3_reg, hb_s2_reg, hb_s1_reg} <= {hb_s2_reg, hb_s1_reg, hb_reg};
      {cc_s3_reg, cc_s2_reg, cc_s1_reg} <= {cc_s2_reg, cc_s1_reg, complement_clock};
      bo_s1_reg <= bank_open_reg;
      bank_open_view <= bo_s1_reg;
      dll_reset_pulse <= dll_s2_reg ^ dll_s3_reg;
      if (req_s2_reg != mode_ack_reg) begin
        cfg_word_view <= mode_hold_reg;
        mode_ack_reg <= req_s2_reg;
      end
    end
  end

  // Both halves of the clock pair must keep moving for the link to count as alive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_age_reg <= ALIVE_TIMEOUT;
      cc_age_reg <= ALIVE_TIMEOUT;
      clock_pair_ok <= 1'b0;
    end else if (clk_en) begin
      hb_age_reg <= (hb_s2_reg != hb_s3_reg) ? 5'h00 : hb_age_reg + 5'(hb_age_reg != ALIVE_TIMEOUT);
      cc_age_reg <= (cc_s2_reg != cc_s3_reg) ? 5'h00 : cc_age_reg + 5'(cc_age_reg != ALIVE_TIMEOUT);
      clock_pair_ok <= hb_age_reg != ALIVE_TIMEOUT && cc_age_reg != ALIVE_TIMEOUT;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_read_cl2_quiet;
    is_rd && cur_cl == CL2_CODE ##1 (link_en && !is_rd && !is_wr)[*2];
  endsequence

  sequence s_read_bl8_cl3;
    is_rd && cur_cl == CL3_CODE && cur_bl_log == 2'd3 ##1 (link_en && !is_rd && !is_wr)[*3];
  endsequence

  a_mode_set_load: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    is_mset |=> mode_reg[12:9] == $past(addr[12:9]) && mode_reg[7:0] == $past(addr[7:0]))
    else $error("mode word not loaded by mode set");

  a_dll_self_clear: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    is_mset && addr[DLL_RESET_BIT] ##1 (link_en && !is_mset) |=> !mode_reg[DLL_RESET_BIT])
    else $error("dll reset bit did not clear itself");

  a_read_latency: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    s_read_cl2_quiet |=> dq_oe && dqs_out_rise && !$past(dq_oe))
    else $error("first read word not at latency two");

  a_burst_length: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    s_read_bl8_cl3 ##1 (link_en && !is_rd && !is_wr)[*4] |=> $past(dq_oe, 4) && !$past(dq_oe, 5) && !dq_oe)
    else $error("eight-location burst not four cycles");

  a_block_wrap: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    st_reg == ST_XFER |-> ((lane_col[1] ^ b_col_reg) & ~{{(COL_W-3){1'b0}}, ddrb_blk_mask(b_bl_log_reg)}) == '0)
    else $error("burst left its aligned block");

  a_pair_order: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    st_reg == ST_XFER && word_reg == 3'd0 |->
      lane_col[0] == b_col_reg && lane_col[1][0] == !b_col_reg[0])
    else $error("burst does not start at the given column");

  a_auto_precharge: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    link_en && at_last && b_ap_reg && !is_act |=> !bank_open_reg[$past(b_bank_reg)])
    else $error("auto precharge left the row open");

  a_write_capture: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    wr_take && lane_idx[0] != lane_idx[1] |=> mem[$past(lane_idx[0])] == $past(dq_in_rise))
    else $error("rise-half write data not stored");

  a_half_shift: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    link_en && st_reg == ST_XFER && !b_wr_reg && b_half_reg && !at_last |=> dqs_oe && !dqs_out_rise && dqs_out_fall)
    else $error("half-cycle latency strobe misplaced");

  a_no_drive_write: assert property (@(posedge true_clock) disable iff (!link_rst_n)
    link_en && st_reg == ST_XFER && b_wr_reg |=> !dq_oe && !dqs_oe)
    else $error("device drove pins during a write");

endmodule // ddrb_device

// ===== dv/ddrb_ctrl_model.sv
// Memory controller model: drives link commands and write bursts.
// Assumes a free-running link clock; the bench calls its tasks by hierarchy.
module ddrb_ctrl_model
  import ddrb_pkg::*;
#(
  parameter int DQ_W = 8
) (
  input wire logic true_clock,
  output logic cmd_sel_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_en_n,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [ADDR_W-1:0] addr,
  output logic [DQ_W-1:0] dq_in_rise,
  output logic [DQ_W-1:0] dq_in_fall,
  output logic dqs_in_rise,
  output logic dqs_in_fall
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {cmd_sel_n, row_strobe_n, col_strobe_n, write_en_n} = 4'hf;
    {bank_select_high, bank_select_low} = 2'h0;
    addr = '0;
    dq_in_rise = '0;
    dq_in_fall = '1;
    {dqs_in_rise, dqs_in_fall} = 2'h0;
  end

  // ----------------------------------------
  // Command and write-burst tasks
  // ----------------------------------------
  // Ends just after the edge that registered the command
  task automatic issue(input logic [2:0] code, input logic [1:0] bank, input logic [ADDR_W-1:0] a);
    @(posedge true_clock);
    #1;
    cmd_sel_n = 1'b0;
    {row_strobe_n, col_strobe_n, write_en_n} = code;
    {bank_select_high, bank_select_low} = bank;
    addr = a;
    @(posedge true_clock);
    #1;
    cmd_sel_n = 1'b1;
    addr = ~a; // Released lines must not look like the last value
  endtask

  // Beats given in burst order, beat k in byte k
  task automatic write_beats(input int bl, input logic [63:0] d);
    for (int i = 0; i < bl; i += 2) begin
      dq_in_rise = d[8*i+:8];
      dq_in_fall = d[8*i+8+:8];
      {dqs_in_rise, dqs_in_fall} = 2'h2;
      @(posedge true_clock);
      #1;
    end
    dq_in_rise = ~dq_in_rise;
    dq_in_fall = ~dq_in_fall;
    {dqs_in_rise, dqs_in_fall} = 2'h1;
  endtask
endmodule // ddrb_ctrl_model

// ===== dv/tb.sv
// Bench for the burst device: mode words, writes, reads in all orders and latencies.
// Assumes the controller model drives the link; bank 1 row 1 holds the test data.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ddrb_pkg::*;

  logic clk, rst_n, clk_en, true_clock, cmd_sel_n, row_strobe_n, col_strobe_n, write_en_n;
  logic bank_select_low, bank_select_high, dqs_in_rise, dqs_in_fall, dq_oe, dqs_out_rise;
  logic dqs_out_fall, dqs_oe, dll_reset_pulse, clock_pair_ok;
  logic [ADDR_W-1:0] addr, cfg_word_view;
  logic [7:0] dq_in_rise, dq_in_fall, dq_out_rise, dq_out_fall;
  logic [NUM_BANKS-1:0] bank_open_view;
  int fails = 0, checked = 0, pulses = 0, cycles = 0;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    true_clock = 1'b0;
    #3;
    forever #7.5 true_clock = ~true_clock;
  end

  ddrb_device dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .true_clock(true_clock),
    .complement_clock(~true_clock), .cmd_sel_n(cmd_sel_n), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .write_en_n(write_en_n), .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high), .addr(addr), .dq_in_rise(dq_in_rise), .dq_in_fall(dq_in_fall),
    .dqs_in_rise(dqs_in_rise), .dqs_in_fall(dqs_in_fall), .dq_out_rise(dq_out_rise),
    .dq_out_fall(dq_out_fall), .dq_oe(dq_oe), .dqs_out_rise(dqs_out_rise), .dqs_out_fall(dqs_out_fall),
    .dqs_oe(dqs_oe), .cfg_word_view(cfg_word_view), .bank_open_view(bank_open_view),
    .dll_reset_pulse(dll_reset_pulse), .clock_pair_ok(clock_pair_ok));

  ddrb_ctrl_model ctrl (.true_clock(true_clock), .cmd_sel_n(cmd_sel_n), .row_strobe_n(row_strobe_n),
    .col_strobe_n(col_strobe_n), .write_en_n(write_en_n), .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high), .addr(addr), .dq_in_rise(dq_in_rise), .dq_in_fall(dq_in_fall),
    .dqs_in_rise(dqs_in_rise), .dqs_in_fall(dqs_in_fall));

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Sampled on the falling edge so the pulse is never read in its launch step
  always @(negedge clk) begin
    if (dll_reset_pulse === 1'b1) pulses++;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  // Every column the bench writes holds a value derived from its own address
  function automatic logic [7:0] colf(input logic [3:0] c);
    return 8'h40 + {4'h0, c};
  endfunction

  function automatic logic [3:0] bcol(input logic [3:0] s, input int b, input int bl, input logic ilv);
    logic [3:0] m, off;
    m = 4'(bl - 1);
    off = ilv ? (s ^ 4'(b)) : (s + 4'(b));
    return (s & ~m) | (off & m);
  endfunction

  // ----------------------------------------
  // Link operations
  // ----------------------------------------
  task automatic mset(input logic [12:0] w, input logic [1:0] bank, input logic [12:0] expv);
    ctrl.issue(CMD_MODE_SET, bank, w);
    repeat (12) @(posedge clk);
    #1;
    chk("cfg_word_view", 16'(cfg_word_view), 16'(expv));
  endtask

  // Close all banks before the mode set, then reopen bank 1 row 1
  task automatic setmode(input logic [12:0] w);
    ctrl.issue(CMD_PRECHARGE, 2'h0, 13'h0400);
    ctrl.issue(CMD_MODE_SET, MODE_BANK_SEL, w);
    repeat (4) @(posedge true_clock);
    ctrl.issue(CMD_ACTIVE, 2'h1, 13'h0001);
  endtask

  task automatic wr(input int bl, input logic ilv, input logic [3:0] s);
    logic [63:0] d;
    d = '0;
    for (int b = 0; b < bl; b++) d[8*b+:8] = colf(bcol(s, b, bl, ilv));
    ctrl.issue(CMD_WRITE, 2'h1, {9'h0, s});
    ctrl.write_beats(bl, d);
    repeat (3) @(posedge true_clock);
  endtask

  task automatic rd(input logic [12:0] w, input logic [3:0] s, input logic ap);
    int bl, half, n, hr, hf;
    bl = 2 << (w[2:0] - 1);
    half = (w[6:4] == CL25_CODE) ? 1 : 0;
    n = bl / 2 + half;
    ctrl.issue(CMD_READ, 2'h1, {2'h0, ap, 6'h0, s});
    repeat ((w[6:4] == CL3_CODE) ? 3 : 2) @(posedge true_clock);
    #2;
    for (int k = 0; k < n; k++) begin
      chk("dq_oe", 16'(dq_oe), 16'h1);
      chk("dqs_oe", 16'(dqs_oe), 16'h1);
      chk("dqs_out", 16'({dqs_out_rise, dqs_out_fall}), (half != 0) ? 16'(k < n - 1) : 16'h2);
      hr = 2 * k - half;
      hf = hr + 1;
      if (hr >= 0) chk("dq_out_rise", 16'(dq_out_rise), 16'(colf(bcol(s, hr, bl, w[3]))));
      if (hf < bl) chk("dq_out_fall", 16'(dq_out_fall), 16'(colf(bcol(s, hf, bl, w[3]))));
      @(posedge true_clock);
      #2;
    end
    chk("dq_oe end", 16'(dq_oe), 16'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  logic [12:0] words [4] = '{13'h023, 13'h03b, 13'h062, 13'h039};
  logic [3:0] starts [4] = '{4'h3, 4'h5, 4'h9, 4'h7};

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (10) @(posedge true_clock);
    mset(13'h0123, 2'h0, 13'h0023);
    chk("dll pulses", 16'(pulses), 16'h1);
    mset(13'h0032, 2'h1, 13'h0023);
    @(posedge clk);
    #1;
    clk_en = 1'b0;
    // The enable needs two link edges to reach the command decoder
    repeat (3) @(posedge true_clock);
    mset(13'h0033, 2'h0, 13'h0023);
    clk_en = 1'b1;
    repeat (6) @(posedge true_clock);
    repeat (12) @(posedge clk);
    #1;
    chk("cfg_word_view held", 16'(cfg_word_view), 16'h0023);
    mset(13'h0023, 2'h0, 13'h0023);
    chk("dll pulses", 16'(pulses), 16'h1);
    ctrl.issue(CMD_ACTIVE, 2'h1, 13'h0001);
    repeat (12) @(posedge clk);
    #1;
    chk("bank_open_view", 16'(bank_open_view), 16'h2);
    wr(8, 1'b0, 4'h0);
    setmode(13'h02a);
    wr(4, 1'b1, 4'h9);
    for (int i = 0; i < 4; i++) begin
      setmode(words[i]);
      rd(words[i], starts[i], 1'b0);
    end
    setmode(13'h022);
    rd(13'h022, 4'h2, 1'b1);
    repeat (12) @(posedge clk);
    #1;
    chk("bank_open_view", 16'(bank_open_view), 16'h0);
    chk("clock_pair_ok", 16'(clock_pair_ok), 16'h1);
    conclude();
  end
endmodule // tb
